// ===== design/ssir_defines.svh
// offsets, bit positions, reset values of the status and interrupt register bank
`ifndef SSIR_DEFINES_SVH
`define SSIR_DEFINES_SVH
`define SSIR_OFF_BUS_STATUS_ONE 8'h0e
`define SSIR_OFF_BUS_STATUS_TWO 8'h0f
`define SSIR_OFF_TABLE_BASE     8'h10
`define SSIR_OFF_INTERRUPT_STATUS_REG          8'h14
`define SSIR_OFF_CHIP_TEST_TWO  8'h1a
`define SSIR_OFF_IRQ_ENABLE     8'h3c
`define SSIR_BIT_ABORT          7
`define SSIR_BIT_SOFT_RESET_BIT           6
`define SSIR_BIT_SIGNAL_PROCESS_FLAG           5
`define SSIR_BIT_SEM            4
`define SSIR_BIT_CON            3
`define SSIR_BIT_ON_THE_FLY_IRQ           2
`define SSIR_BIT_SIP            1
`define SSIR_BIT_DIP            0
`define SSIR_BIT_CT2_SIGNAL_PROCESS_FLAG       6
`define SSIR_BIT_IRQ_EN         0
`define SSIR_FIFO_MAX           5'h10
`define SSIR_RST_INTERRUPT_STATUS_REG          8'h00
`define SSIR_RST_LAST_DROP_FLAG           1'b1
`define SSIR_RST_IRQ_EN         1'b0
`define SSIR_RST_TABLE_BASE     32'h0000_0000
`endif

// ===== design/ssir_pkg.sv
// types of the status and interrupt register bank
package ssir_pkg;
   typedef struct packed {
      logic [7:0]  rd_data;
      logic        in_upper_full;
      logic        in_upper_parity;
      logic        hold_upper_full;
      logic        out_upper_full;
      logic        last_drop_flag;
      logic [31:0] table_base;
      logic        abort;
      logic        soft_reset_bit;
      logic        signal_process_flag;
      logic        shared_flag_bit;
      logic        link_attached_flag;
      logic        on_the_fly_irq;
      logic        bus_side_irq_pending;
      logic        transfer_engine_irq_pending;
      logic        irq_en;
      logic        irq;
   } ssir_state_t;
endpackage : ssir_pkg

// ===== design/ssir_regs.sv
// status, table base pointer and interrupt status registers of the bus function
//
// Local design decision: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "ssir_defines.svh"
module ssir_regs #(
   parameter int ADDR_W     = 8,
   parameter int BUS_CAUSES = 11,
   parameter int ENG_CAUSES = 6
) (
   // clock and reset
   input  wire logic                  i_clk_sys,
   input  wire logic                  i_rst_n,
   // register port
   input  wire logic [ADDR_W-1:0]     i_addr,
   input  wire logic [7:0]            i_wr_data,
   input  wire logic                  i_wr_stb,
   input  wire logic                  i_rd_stb,
   output logic [7:0]                 o_rd_data,
   // data path status
   input  wire logic                  i_sync_mode,
   input  wire logic                  i_in_upper_load,
   input  wire logic                  i_in_upper_parity,
   input  wire logic                  i_in_upper_unload,
   input  wire logic                  i_out_upper_load,
   input  wire logic                  i_out_upper_send,
   input  wire logic                  i_hold_upper_send,
   input  wire logic [4:0]            i_fifo_count,
   input  wire logic                  i_cable_sense_pin,
   input  wire logic                  i_upper_parity_live,
   // engine events
   input  wire logic                  i_con_set,
   input  wire logic                  i_con_clear,
   input  wire logic                  i_block_move,
   input  wire logic                  i_table_base_load,
   input  wire logic [31:0]           i_table_base_data,
   input  wire logic                  i_sem_set,
   input  wire logic                  i_irq_on_the_fly_instruction,
   input  wire logic [BUS_CAUSES-1:0] i_bus_irq_cause,
   input  wire logic                  i_bus_irq_ack,
   input  wire logic [ENG_CAUSES-1:0] i_eng_irq_cause,
   input  wire logic                  i_eng_irq_ack,
   // control outputs
   output logic                       o_abort_req,
   output logic                       o_soft_reset,
   output logic                       o_signal_process,
   output logic                       o_shared_flag,
   output logic                       o_link_attached,
   output logic [31:0]                o_table_base,
   output logic                       o_irq
);

   initial begin
      if (ADDR_W < 6 || ADDR_W > 16 || BUS_CAUSES < 1 || ENG_CAUSES < 1) begin
         $error("ssir_regs: unsupported parameter values");
      end
   end

   localparam logic [ADDR_W-1:0] A_ONE = ADDR_W'(`SSIR_OFF_BUS_STATUS_ONE);
   localparam logic [ADDR_W-1:0] A_TWO = ADDR_W'(`SSIR_OFF_BUS_STATUS_TWO);
   localparam logic [ADDR_W-1:0] A_TB0 = ADDR_W'(`SSIR_OFF_TABLE_BASE);
   localparam logic [ADDR_W-1:0] A_TB1 = ADDR_W'(`SSIR_OFF_TABLE_BASE + 1);
   localparam logic [ADDR_W-1:0] A_TB2 = ADDR_W'(`SSIR_OFF_TABLE_BASE + 2);
   localparam logic [ADDR_W-1:0] A_TB3 = ADDR_W'(`SSIR_OFF_TABLE_BASE + 3);
   localparam logic [ADDR_W-1:0] A_IST = ADDR_W'(`SSIR_OFF_INTERRUPT_STATUS_REG);
   localparam logic [ADDR_W-1:0] A_CT2 = ADDR_W'(`SSIR_OFF_CHIP_TEST_TWO);
   localparam logic [ADDR_W-1:0] A_IEN = ADDR_W'(`SSIR_OFF_IRQ_ENABLE);

   ssir_pkg::ssir_state_t s_reg;
   ssir_pkg::ssir_state_t s_next;
   logic [7:0]            interrupt_status_reg_view;
   logic [7:0]            two_view;
   logic                  ist_wr;

   assign ist_wr = i_wr_stb && (i_addr == A_IST);

   always_comb begin
      interrupt_status_reg_view = {s_reg.abort, s_reg.soft_reset_bit, s_reg.signal_process_flag, s_reg.shared_flag_bit,
                    s_reg.link_attached_flag, s_reg.on_the_fly_irq, s_reg.bus_side_irq_pending, s_reg.transfer_engine_irq_pending};
      two_view   = {s_reg.in_upper_full, s_reg.hold_upper_full,
                    s_reg.out_upper_full, i_fifo_count[4],
                    s_reg.in_upper_parity, i_cable_sense_pin,
                    s_reg.last_drop_flag, i_upper_parity_live};

      s_next         = s_reg;
      s_next.rd_data = 8'h00;

      // data path latches
      if (i_in_upper_unload) begin
         s_next.in_upper_full = 1'b0;
      end
      if (i_in_upper_load && !i_sync_mode) begin
         s_next.in_upper_full   = 1'b1;
         s_next.in_upper_parity = i_in_upper_parity;
      end
      if (i_hold_upper_send) begin
         s_next.hold_upper_full = 1'b0;
      end
      if (i_out_upper_send) begin
         s_next.out_upper_full = 1'b0;
         if (i_sync_mode) begin
            s_next.hold_upper_full = 1'b1;
         end
      end
      if (i_out_upper_load) begin
         s_next.out_upper_full = 1'b1;
      end

      // register reads
      if (i_rd_stb) begin
         unique case (i_addr)
            A_ONE: s_next.rd_data = {i_fifo_count[3:0], 4'h0};
            A_TWO: s_next.rd_data = two_view;
            A_TB0: s_next.rd_data = s_reg.table_base[7:0];
            A_TB1: s_next.rd_data = s_reg.table_base[15:8];
            A_TB2: s_next.rd_data = s_reg.table_base[23:16];
            A_TB3: s_next.rd_data = s_reg.table_base[31:24];
            A_IST: s_next.rd_data = interrupt_status_reg_view;
            A_CT2: begin
               s_next.rd_data = {1'b0, s_reg.signal_process_flag, 6'h00};
               s_next.signal_process_flag    = 1'b0;
            end
            A_IEN: s_next.rd_data = {7'h00, s_reg.irq_en};
            default: s_next.rd_data = 8'h00;
         endcase
      end

      // register writes
      if (i_wr_stb) begin
         unique case (i_addr)
            A_TB0: s_next.table_base[7:0]   = i_wr_data;
            A_TB1: s_next.table_base[15:8]  = i_wr_data;
            A_TB2: s_next.table_base[23:16] = i_wr_data;
            A_TB3: s_next.table_base[31:24] = i_wr_data;
            A_IST: begin
               s_next.abort = i_wr_data[`SSIR_BIT_ABORT];
               s_next.soft_reset_bit  = i_wr_data[`SSIR_BIT_SOFT_RESET_BIT];
               s_next.signal_process_flag  = i_wr_data[`SSIR_BIT_SIGNAL_PROCESS_FLAG];
               s_next.shared_flag_bit   = i_wr_data[`SSIR_BIT_SEM];
               if (i_wr_data[`SSIR_BIT_ON_THE_FLY_IRQ]) begin
                  s_next.on_the_fly_irq = 1'b0;
               end
            end
            A_IEN: s_next.irq_en = i_wr_data[`SSIR_BIT_IRQ_EN];
            default: s_next.irq_en = s_reg.irq_en;
         endcase
      end
      if (i_table_base_load) begin
         s_next.table_base = i_table_base_data;
      end

      // hardware events, set wins over clear
      if (i_bus_irq_ack) begin
         s_next.bus_side_irq_pending = 1'b0;
      end
      if (i_eng_irq_ack) begin
         s_next.transfer_engine_irq_pending = 1'b0;
      end
      if (i_con_clear) begin
         s_next.link_attached_flag = 1'b0;
      end
      if (i_con_set) begin
         s_next.link_attached_flag = 1'b1;
      end
      if (i_sem_set) begin
         s_next.shared_flag_bit = 1'b1;
      end
      if (i_irq_on_the_fly_instruction) begin
         s_next.on_the_fly_irq = 1'b1;
      end
      if (|i_bus_irq_cause) begin
         s_next.bus_side_irq_pending = 1'b1;
      end
      if (|i_eng_irq_cause) begin
         s_next.transfer_engine_irq_pending = 1'b1;
      end
      // abort write raises engine pending, beats ack
      if (i_wr_stb && i_addr == A_IST && i_wr_data[`SSIR_BIT_ABORT]) begin
         s_next.transfer_engine_irq_pending = 1'b1;
      end
      s_next.last_drop_flag = !s_reg.link_attached_flag || (s_reg.last_drop_flag && !i_block_move);

      // soft reset holds operating registers except the table base at defaults
      if (s_next.soft_reset_bit) begin
         s_next.in_upper_full   = 1'b0;
         s_next.in_upper_parity = 1'b0;
         s_next.hold_upper_full = 1'b0;
         s_next.out_upper_full  = 1'b0;
         s_next.last_drop_flag            = `SSIR_RST_LAST_DROP_FLAG;
         s_next.abort           = 1'b0;
         s_next.signal_process_flag            = 1'b0;
         s_next.shared_flag_bit             = 1'b0;
         s_next.link_attached_flag             = 1'b0;
         s_next.on_the_fly_irq            = 1'b0;
         s_next.bus_side_irq_pending             = 1'b0;
         s_next.transfer_engine_irq_pending             = 1'b0;
         s_next.irq_en          = `SSIR_RST_IRQ_EN;
      end
      s_next.irq = s_next.irq_en && (s_next.bus_side_irq_pending || s_next.transfer_engine_irq_pending || s_next.on_the_fly_irq);
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         s_reg                 <= '0;
         s_reg.last_drop_flag            <= `SSIR_RST_LAST_DROP_FLAG;
         s_reg.table_base      <= `SSIR_RST_TABLE_BASE;
         s_reg.irq_en          <= `SSIR_RST_IRQ_EN;
         {s_reg.abort, s_reg.soft_reset_bit, s_reg.signal_process_flag, s_reg.shared_flag_bit,
          s_reg.link_attached_flag, s_reg.on_the_fly_irq, s_reg.bus_side_irq_pending, s_reg.transfer_engine_irq_pending} <= `SSIR_RST_INTERRUPT_STATUS_REG;
      end else begin
         s_reg <= s_next;
      end
   end

   assign o_rd_data        = s_reg.rd_data;
   assign o_abort_req      = s_reg.abort;
   assign o_soft_reset     = s_reg.soft_reset_bit;
   assign o_signal_process = s_reg.signal_process_flag;
   assign o_shared_flag    = s_reg.shared_flag_bit;
   assign o_link_attached  = s_reg.link_attached_flag;
   assign o_table_base     = s_reg.table_base;
   assign o_irq            = s_reg.irq;

   // checks
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_rst_n);

   chk_sync_bypass: assert property (
      (i_in_upper_load && i_sync_mode && !s_reg.in_upper_full && !s_reg.soft_reset_bit)
      |=> !s_reg.in_upper_full)
      else $error("sync receive filled input latch");
   chk_hold_stage: assert property (
      (i_out_upper_send && !i_sync_mode && !i_hold_upper_send && !s_reg.hold_upper_full)
      |=> !s_reg.hold_upper_full)
      else $error("async send used holding register");
   chk_status_two_read: assert property (
      (i_rd_stb && i_addr == A_TWO)
      |=> o_rd_data[4] == $past(i_fifo_count[4]) && o_rd_data[2] == $past(i_cable_sense_pin))
      else $error("status two fields wrong");
   chk_last_drop: assert property (
      !o_link_attached |=> s_reg.last_drop_flag)
      else $error("last drop not set while unattached");
   chk_abort_irq: assert property (
      (i_wr_stb && i_addr == A_IST && i_wr_data[7] && !i_wr_data[6] && !s_reg.soft_reset_bit)
      |=> o_abort_req && s_reg.transfer_engine_irq_pending)
      else $error("abort write did not raise engine pending");
   chk_soft_reset_bit_hold: assert property (
      (o_soft_reset && !(i_wr_stb && i_addr == A_IST)) |=> o_soft_reset && !o_link_attached)
      else $error("soft reset cleared itself");
   chk_signal_process_flag_clear: assert property (
      (i_rd_stb && i_addr == A_CT2) |=> !o_signal_process && o_rd_data[6] == $past(o_signal_process))
      else $error("signal process not cleared by read");
   chk_on_the_fly_irq_sticky: assert property (
      (s_reg.on_the_fly_irq && !(i_wr_stb && i_addr == A_IST && i_wr_data[2]) && !o_soft_reset
       && !(i_wr_stb && i_addr == A_IST && i_wr_data[6])) |=> s_reg.on_the_fly_irq)
      else $error("on-the-fly bit lost");
   chk_bus_pending: assert property (
      ((|i_bus_irq_cause) && !o_soft_reset && !(i_wr_stb && i_addr == A_IST && i_wr_data[6]))
      |=> s_reg.bus_side_irq_pending)
      else $error("bus cause did not set pending");
   chk_irq_out: assert property (
      ##1 (o_irq == (s_reg.irq_en && (s_reg.bus_side_irq_pending || s_reg.transfer_engine_irq_pending || s_reg.on_the_fly_irq))))
      else $error("irq output mismatch");
   chk_in_full_set: assert property (
      (i_in_upper_load && !i_sync_mode && !s_reg.soft_reset_bit && !ist_wr)
      |=> s_reg.in_upper_full)
      else $error("async receive did not fill input latch");
   chk_parity_latch: assert property (
      (i_in_upper_load && !i_sync_mode && !s_reg.soft_reset_bit && !ist_wr)
      |=> s_reg.in_upper_parity == $past(i_in_upper_parity))
      else $error("latched parity wrong");
   chk_in_full_read: assert property (
      (i_rd_stb && i_addr == A_TWO)
      |=> o_rd_data[7] == $past(s_reg.in_upper_full))
      else $error("input latch full bit misread");
   chk_out_full_set: assert property (
      (i_out_upper_load && !s_reg.soft_reset_bit && !ist_wr)
      |=> s_reg.out_upper_full)
      else $error("output latch full not set");
   chk_hold_fill: assert property (
      (i_out_upper_send && i_sync_mode && !s_reg.soft_reset_bit && !ist_wr)
      |=> s_reg.hold_upper_full)
      else $error("sync send skipped holding register");
   chk_status_two_map: assert property (
      (i_rd_stb && i_addr == A_TWO)
      |=> o_rd_data[0] == $past(i_upper_parity_live) && o_rd_data[1] == $past(s_reg.last_drop_flag))
      else $error("live parity or last drop misread");
   chk_fifo_low_read: assert property (
      (i_rd_stb && i_addr == A_ONE)
      |=> o_rd_data == {$past(i_fifo_count[3:0]), 4'h0})
      else $error("fifo count low bits wrong");
   chk_fifo_full_count: assert property (
      (i_rd_stb && i_addr == A_TWO && i_fifo_count == `SSIR_FIFO_MAX)
      |=> o_rd_data[4])
      else $error("fifo count sixteen not shown");
   chk_drop_clear: assert property (
      (s_reg.link_attached_flag && i_block_move && !s_reg.soft_reset_bit && !(ist_wr && i_wr_data[6]))
      |=> !s_reg.last_drop_flag)
      else $error("block move did not clear last drop");
   chk_table_write: assert property (
      (i_wr_stb && i_addr == A_TB0 && !i_table_base_load)
      |=> o_table_base[7:0] == $past(i_wr_data))
      else $error("table base byte write lost");
   chk_table_load: assert property (
      i_table_base_load
      |=> o_table_base == $past(i_table_base_data))
      else $error("table base load lost");
   chk_table_keep: assert property (
      (!i_table_base_load && !i_wr_stb)
      |=> $stable(o_table_base))
      else $error("table base changed unasked");
   chk_soft_reset_bit_defaults: assert property (
      s_reg.soft_reset_bit
      |-> !s_reg.link_attached_flag && !s_reg.bus_side_irq_pending && !s_reg.transfer_engine_irq_pending && !s_reg.on_the_fly_irq && s_reg.last_drop_flag && !s_reg.irq_en)
      else $error("soft reset left state set");
   chk_soft_reset_bit_release: assert property (
      (o_soft_reset && ist_wr && !i_wr_data[6])
      |=> !o_soft_reset)
      else $error("soft reset not released");
   chk_signal_process_flag_write: assert property (
      (ist_wr && !i_wr_data[6])
      |=> o_signal_process == $past(i_wr_data[5]))
      else $error("signal process write lost");
   chk_sem_script: assert property (
      (i_sem_set && !s_reg.soft_reset_bit && !ist_wr)
      |=> o_shared_flag)
      else $error("script did not set shared flag");
   chk_sem_host: assert property (
      (ist_wr && i_wr_data[4] && !i_wr_data[6])
      |=> o_shared_flag)
      else $error("host did not set shared flag");
   chk_con_set: assert property (
      (i_con_set && !s_reg.soft_reset_bit && !ist_wr)
      |=> o_link_attached)
      else $error("attached flag not set");
   chk_on_the_fly_irq_set: assert property (
      (i_irq_on_the_fly_instruction && !s_reg.soft_reset_bit && !(ist_wr && i_wr_data[6]))
      |=> s_reg.on_the_fly_irq)
      else $error("on-the-fly bit not set");
   chk_on_the_fly_irq_clear: assert property (
      (ist_wr && i_wr_data[2] && !i_irq_on_the_fly_instruction)
      |=> !s_reg.on_the_fly_irq)
      else $error("on-the-fly bit not cleared");
   chk_eng_pending: assert property (
      ((|i_eng_irq_cause) && !s_reg.soft_reset_bit && !ist_wr)
      |=> s_reg.transfer_engine_irq_pending)
      else $error("engine cause did not set pending");

   cov_abort: cover property (o_abort_req ##1 s_reg.transfer_engine_irq_pending);
   cov_fly: cover property (s_reg.on_the_fly_irq && o_irq);
   cov_soft_reset_bit: cover property (o_soft_reset ##1 !o_soft_reset);
   cov_disc: cover property (o_link_attached && s_reg.last_drop_flag);
   cov_sync_hold: cover property (s_reg.hold_upper_full && !s_reg.out_upper_full);

endmodule : ssir_regs
`default_nettype wire

// ===== verification/ssir_eng_model.sv
// engine and data path side model: event pulses and live levels
`timescale 1ns/1ps
`default_nettype none
module ssir_eng_model (
   // clock
   input  wire logic   i_clk_sys,
   // events and levels
   output logic [29:0] o_ev,
   output logic [40:0] o_lvl
);
   initial begin
      o_ev  = 30'h0;
      o_lvl = 41'h0;
   end
   // one-cycle event pulse, launched just after an edge
   task automatic fire(input logic [29:0] m);
      o_ev <= m;
      @(posedge i_clk_sys);
      o_ev <= 30'h0;
      @(posedge i_clk_sys);
   endtask : fire
   task automatic setl(input logic [40:0] v);
      o_lvl <= v;
      @(posedge i_clk_sys);
   endtask : setl
endmodule : ssir_eng_model
`default_nettype wire

// ===== verification/tb_top.sv
// self-checking bench for the status and interrupt register bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic        i_clk_sys;
   logic        i_rst_n;
   logic [7:0]  addr, wdat, rd_data;
   logic        wr_stb, rd_stb;
   logic        abort_req, soft_reset, sig_proc, shared, attached, irq;
   logic [31:0] table_base;
   logic [29:0] ev;
   logic [40:0] lvl;
   wire logic        sync_mode = lvl[0];
   wire logic        in_load   = ev[0];
   wire logic        in_par    = lvl[1];
   wire logic        in_unload = ev[1];
   wire logic        out_load  = ev[2];
   wire logic        out_send  = ev[3];
   wire logic        hold_send = ev[4];
   wire logic [4:0]  fifo_cnt  = lvl[8:4];
   wire logic        cable     = lvl[2];
   wire logic        live_par  = lvl[3];
   wire logic        con_set   = ev[5];
   wire logic        con_clr   = ev[6];
   wire logic        blk_move  = ev[7];
   wire logic        tb_load   = ev[8];
   wire logic [31:0] tb_data   = lvl[40:9];
   wire logic        sem_set   = ev[9];
   wire logic        fly       = ev[10];
   wire logic [10:0] bus_cause = ev[23:13];
   wire logic        bus_ack   = ev[11];
   wire logic [5:0]  eng_cause = ev[29:24];
   wire logic        eng_ack   = ev[12];
   int          n_errors;
   int          comparisons;

   ssir_eng_model eng (.i_clk_sys(i_clk_sys), .o_ev(ev), .o_lvl(lvl));

   ssir_regs i_dut (
      .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_addr(addr), .i_wr_data(wdat),
      .i_wr_stb(wr_stb), .i_rd_stb(rd_stb), .o_rd_data(rd_data),
      .i_sync_mode(sync_mode), .i_in_upper_load(in_load), .i_in_upper_parity(in_par),
      .i_in_upper_unload(in_unload), .i_out_upper_load(out_load),
      .i_out_upper_send(out_send), .i_hold_upper_send(hold_send),
      .i_fifo_count(fifo_cnt), .i_cable_sense_pin(cable),
      .i_upper_parity_live(live_par), .i_con_set(con_set), .i_con_clear(con_clr),
      .i_block_move(blk_move), .i_table_base_load(tb_load), .i_table_base_data(tb_data),
      .i_sem_set(sem_set), .i_irq_on_the_fly_instruction(fly),
      .i_bus_irq_cause(bus_cause), .i_bus_irq_ack(bus_ack), .i_eng_irq_cause(eng_cause),
      .i_eng_irq_ack(eng_ack), .o_abort_req(abort_req), .o_soft_reset(soft_reset),
      .o_signal_process(sig_proc), .o_shared_flag(shared), .o_link_attached(attached),
      .o_table_base(table_base), .o_irq(irq));

   always #20 i_clk_sys = ~i_clk_sys;

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      addr <= a;
      wdat <= d;
      wr_stb <= 1'b1;
      @(posedge i_clk_sys);
      wr_stb <= 1'b0;
      @(posedge i_clk_sys);
   endtask : wr

   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge i_clk_sys);
      rd_stb <= 1'b0;
      @(negedge i_clk_sys);
      chk({24'h0, rd_data & m}, {24'h0, e & m});
      @(posedge i_clk_sys);
   endtask : rd

   task automatic wrap_up;
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : wrap_up

   initial begin
      i_clk_sys = 1'b0;
      i_rst_n = 1'b0;
      addr = 8'h00;
      wdat = 8'h00;
      wr_stb = 1'b0;
      rd_stb = 1'b0;
      n_errors = 0;
      comparisons = 0;
      repeat (16) @(posedge i_clk_sys);
      i_rst_n <= 1'b1;
      @(posedge i_clk_sys);
      rd(8'h14, 8'h00, 8'hff);
      rd(8'h0f, 8'h02, 8'hf7);
      rd(8'h20, 8'h00, 8'hff);
      eng.setl({32'h0, 5'h10, 4'b1100});
      rd(8'h0f, 8'h17, 8'h1f);
      rd(8'h0e, 8'h00, 8'hff);
      eng.setl({32'h0, 5'h0f, 4'b0000});
      rd(8'h0e, 8'hf0, 8'hff);
      wr(8'h0f, 8'hff);
      rd(8'h0f, 8'h02, 8'hf7);
      eng.setl(41'h3);
      eng.fire(30'h1);
      rd(8'h0f, 8'h00, 8'h88);
      eng.setl(41'h2);
      eng.fire(30'h1);
      rd(8'h0f, 8'h88, 8'h88);
      eng.fire(30'h2);
      rd(8'h0f, 8'h00, 8'h80);
      eng.fire(30'h4);
      rd(8'h0f, 8'h20, 8'h60);
      eng.fire(30'h8);
      rd(8'h0f, 8'h00, 8'h60);
      eng.setl(41'h1);
      eng.fire(30'h4);
      eng.fire(30'h8);
      rd(8'h0f, 8'h40, 8'h60);
      eng.fire(30'h10);
      rd(8'h0f, 8'h00, 8'h60);
      eng.fire(30'h20);
      rd(8'h14, 8'h08, 8'hff);
      rd(8'h0f, 8'h02, 8'h02);
      chk({31'h0, attached}, 32'h1);
      eng.fire(30'h80);
      rd(8'h0f, 8'h00, 8'h02);
      eng.fire(30'h40);
      rd(8'h14, 8'h00, 8'hff);
      rd(8'h0f, 8'h02, 8'h02);
      for (int i = 0; i < 4; i++) begin
         wr(8'h10 + 8'(i), 8'h11 << i);
      end
      for (int i = 0; i < 4; i++) begin
         rd(8'h10 + 8'(i), 8'h11 << i, 8'hff);
      end
      chk(table_base, 32'h88442211);
      eng.setl({32'hcafe0123, 9'h0});
      eng.fire(30'h100);
      rd(8'h13, 8'hca, 8'hff);
      chk(table_base, 32'hcafe0123);
      wr(8'h3c, 8'h01);
      wr(8'h14, 8'h80);
      rd(8'h14, 8'h81, 8'hff);
      chk({30'h0, abort_req, irq}, 32'h3);
      wr(8'h14, 8'h00);
      eng.fire(30'h1000);
      rd(8'h14, 8'h00, 8'hff);
      chk({31'h0, irq}, 32'h0);
      for (int i = 0; i < 11; i++) begin
         eng.fire(30'h2000 << i);
         rd(8'h14, 8'h02, 8'hff);
         eng.fire(30'h800);
      end
      for (int i = 0; i < 6; i++) begin
         eng.fire(30'h1000000 << i);
         rd(8'h14, 8'h01, 8'hff);
         eng.fire(30'h1000);
      end
      rd(8'h14, 8'h00, 8'hff);
      eng.fire(30'h400);
      rd(8'h14, 8'h04, 8'hff);
      rd(8'h14, 8'h04, 8'hff);
      chk({31'h0, irq}, 32'h1);
      wr(8'h14, 8'h00);
      rd(8'h14, 8'h04, 8'hff);
      wr(8'h14, 8'h04);
      rd(8'h14, 8'h00, 8'hff);
      wr(8'h14, 8'h20);
      rd(8'h14, 8'h20, 8'hff);
      chk({31'h0, sig_proc}, 32'h1);
      rd(8'h1a, 8'h40, 8'hff);
      rd(8'h14, 8'h00, 8'hff);
      eng.fire(30'h200);
      rd(8'h14, 8'h10, 8'hff);
      wr(8'h14, 8'h00);
      wr(8'h14, 8'h10);
      rd(8'h14, 8'h10, 8'hff);
      chk({31'h0, shared}, 32'h1);
      eng.fire(30'h2020);
      wr(8'h14, 8'h40);
      repeat (20) @(posedge i_clk_sys);
      rd(8'h14, 8'h40, 8'hff);
      rd(8'h3c, 8'h00, 8'h01);
      rd(8'h0f, 8'h02, 8'h02);
      chk({29'h0, soft_reset, irq, attached}, 32'h4);
      wr(8'h14, 8'h00);
      rd(8'h14, 8'h00, 8'hff);
      wrap_up();
   end
endmodule : tb_top
`default_nettype wire
